// ==== include/gpsa_pkg.sv ====
package gpsa_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int GPSA_PINS = 8;
  localparam int GPSA_PIN_IDX_W = 3;
  localparam int GPSA_FIRST_PLAIN_PORT = 4;

  // ----------------------------------------------------------------
  // Input synchronisation codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GPSA_IN_PASS = 2'h0;
  localparam logic [1:0] GPSA_IN_SYNC1 = 2'h1;
  localparam logic [1:0] GPSA_IN_SYNC2 = 2'h2;
  localparam logic [1:0] GPSA_IN_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // Output synchronisation codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GPSA_OUT_PASS = 2'h0;
  localparam logic [1:0] GPSA_OUT_SYNC1 = 2'h1;
  localparam logic [1:0] GPSA_OUT_CLK = 2'h2;
  localparam logic [1:0] GPSA_OUT_CLKINV = 2'h3;

  // ----------------------------------------------------------------
  // Sync clock and reset sources
  // ----------------------------------------------------------------
  localparam logic [1:0] GPSA_CLK_HF = 2'h0;
  localparam logic [1:0] GPSA_CLK_FABRIC = 2'h1;
  localparam logic [1:0] GPSA_CLK_PIN = 2'h2;
  localparam logic GPSA_RST_FABRIC = 1'b0;
  localparam logic GPSA_RST_PIN = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPSA_LATCH_RESET = 8'h00;
  localparam logic [7:0] GPSA_READBACK_RESET = 8'h00;
  localparam logic GPSA_FLOP_RESET = 1'b0;

endpackage : gpsa_pkg

// ==== core/gpsa_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpsa_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Shared synchroniser controls
  input wire logic syncTick,
  input wire logic syncRst,
  input wire logic clkLevel,
  // Per-pin configuration
  input wire logic [1:0] inMode,
  input wire logic [1:0] outMode,
  // Data
  input wire logic pinLevel,
  input wire logic outSource,
  output logic fabricIn,
  output logic pinOut
);
  import gpsa_pkg::*;

  logic stage1;
  logic stage2;
  logic outStage;

  // ----------------------------------------------------------------
  // Input stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= GPSA_FLOP_RESET;
      stage2 <= GPSA_FLOP_RESET;
    end else if (syncRst) begin
      stage1 <= GPSA_FLOP_RESET;
      stage2 <= GPSA_FLOP_RESET;
    end else if (syncTick) begin
      stage1 <= pinLevel;
      stage2 <= stage1;
    end
  end

  always_comb begin
    unique case (inMode)
      GPSA_IN_PASS: fabricIn = pinLevel;
      GPSA_IN_SYNC1: fabricIn = stage1;
      GPSA_IN_SYNC2: fabricIn = stage2;
      GPSA_IN_RSVD: fabricIn = pinLevel;
    endcase
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      outStage <= GPSA_FLOP_RESET;
    end else if (syncRst) begin
      outStage <= GPSA_FLOP_RESET;
    end else if (syncTick) begin
      outStage <= outSource;
    end
  end

  // Pass-through stays combinational so the pin follows its source without a clock.
  always_comb begin
    unique case (outMode)
      GPSA_OUT_PASS: pinOut = outSource;
      GPSA_OUT_SYNC1: pinOut = outStage;
      GPSA_OUT_CLK: pinOut = clkLevel;
      GPSA_OUT_CLKINV: pinOut = ~clkLevel;
    endcase
  end

endmodule : gpsa_pin_sync
`default_nettype wire

// ==== core/gpsa_port_adapter.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpsa_port_adapter #(
  parameter int PORT_INDEX = 0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pins
  input wire logic [gpsa_pkg::GPSA_PINS-1:0] pinIn,
  output logic [gpsa_pkg::GPSA_PINS-1:0] pinOut,
  // Fabric side
  input wire logic [gpsa_pkg::GPSA_PINS-1:0] fabricOut,
  output logic [gpsa_pkg::GPSA_PINS-1:0] fabricIn,
  input wire logic fabricSyncClk,
  input wire logic fabricSyncRst,
  // Adapter configuration
  input wire logic [2*gpsa_pkg::GPSA_PINS-1:0] inSyncMode,
  input wire logic [2*gpsa_pkg::GPSA_PINS-1:0] outSyncMode,
  input wire logic [1:0] syncClkSel,
  input wire logic [gpsa_pkg::GPSA_PIN_IDX_W-1:0] syncClkPin,
  input wire logic syncClkEnable,
  input wire logic syncRstSel,
  input wire logic [gpsa_pkg::GPSA_PIN_IDX_W-1:0] syncRstPin,
  output logic configError,
  // Software pin control
  input wire logic [gpsa_pkg::GPSA_PINS-1:0] swControl,
  input wire logic [gpsa_pkg::GPSA_PINS-1:0] latchSetMask,
  input wire logic [gpsa_pkg::GPSA_PINS-1:0] latchClearMask,
  output logic [gpsa_pkg::GPSA_PINS-1:0] pinOutputLatch,
  output logic [gpsa_pkg::GPSA_PINS-1:0] pinStateReadback
);
  import gpsa_pkg::*;

  localparam logic HAS_ADAPTER = (PORT_INDEX < GPSA_FIRST_PLAIN_PORT);

  logic [GPSA_PINS-1:0] pinMeta;
  logic [GPSA_PINS-1:0] pinLevel;
  logic syncClkLevel;
  logic syncClkPrev;
  logic hfImage;
  logic syncTick;
  logic clkLevel;
  logic syncRst;
  logic [2*GPSA_PINS-1:0] effInMode;
  logic [2*GPSA_PINS-1:0] effOutMode;
  logic [GPSA_PINS-1:0] outSource;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous, so even straight mode sees them two cycles late.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta <= GPSA_READBACK_RESET;
      pinLevel <= GPSA_READBACK_RESET;
    end else begin
      pinMeta <= pinIn;
      pinLevel <= pinMeta;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinStateReadback <= GPSA_READBACK_RESET;
    end else begin
      pinStateReadback <= pinLevel;
    end
  end

  // ----------------------------------------------------------------
  // Shared sync clock
  // ----------------------------------------------------------------
  always_comb begin
    unique case (syncClkSel)
      GPSA_CLK_FABRIC: syncClkLevel = fabricSyncClk;
      GPSA_CLK_PIN: syncClkLevel = pinLevel[syncClkPin];
      default: syncClkLevel = hfImage;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      syncClkPrev <= GPSA_FLOP_RESET;
      hfImage <= GPSA_FLOP_RESET;
    end else begin
      syncClkPrev <= syncClkLevel;
      hfImage <= ~hfImage;
    end
  end

  // The fast clock cannot reach a pin as data, so its half-rate image stands in.
  assign clkLevel = syncClkLevel;
  // One tick drives every pin of the port; pins never pick their own clock.
  assign syncTick = syncClkEnable & ((syncClkSel == GPSA_CLK_HF) |
                    (syncClkSel != GPSA_CLK_HF & syncClkLevel & ~syncClkPrev));
  assign syncRst = (syncRstSel == GPSA_RST_PIN) ? pinLevel[syncRstPin] : fabricSyncRst;

  // ----------------------------------------------------------------
  // Plain ports and configuration check
  // ----------------------------------------------------------------
  assign effInMode = HAS_ADAPTER ? inSyncMode : '0;
  assign effOutMode = HAS_ADAPTER ? outSyncMode : '0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      configError <= GPSA_FLOP_RESET;
    end else begin
      configError <= ~HAS_ADAPTER & ((|inSyncMode) | (|outSyncMode));
    end
  end

  // ----------------------------------------------------------------
  // Software output latch
  // ----------------------------------------------------------------
  // A bit both set and cleared in one cycle ends up set.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinOutputLatch <= GPSA_LATCH_RESET;
    end else begin
      pinOutputLatch <= (pinOutputLatch & ~latchClearMask) | latchSetMask;
    end
  end

  assign outSource = (swControl & pinOutputLatch) | (~swControl & fabricOut);

  // ----------------------------------------------------------------
  // Per-pin adapters
  // ----------------------------------------------------------------
  for (genvar p = 0; p < GPSA_PINS; p++) begin : g_pin
    gpsa_pin_sync u_pin (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .syncTick(syncTick),
      .syncRst(syncRst),
      .clkLevel(clkLevel),
      .inMode(effInMode[2*p+1 -: 2]),
      .outMode(effOutMode[2*p+1 -: 2]),
      .pinLevel(pinLevel[p]),
      .outSource(outSource[p]),
      .fabricIn(fabricIn[p]),
      .pinOut(pinOut[p])
    );
  end

endmodule : gpsa_port_adapter
`default_nettype wire

// ==== verif/gpsa_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpsa_fabric_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  // Fabric signals
  output logic [7:0] fabricOut,
  output logic fabricSyncClk
);
  logic [1:0] div;
  // Data moves every cycle, so a late or missed sample cannot match by luck.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fabricOut <= 8'h00;
      div <= 2'h0;
    end else begin
      fabricOut <= fabricOut + 8'h35;
      div <= run ? div + 2'h1 : 2'h0;
    end
  end
  // The fabric clock stands still outside traffic.
  assign fabricSyncClk = div[1];
endmodule : gpsa_fabric_model
`default_nettype wire

// ==== verif/gpsa_port_adapter_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpsa_port_adapter_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Data
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] fabricOut,
  input wire logic [7:0] fabricIn,
  // Configuration
  input wire logic [15:0] inSyncMode,
  input wire logic [15:0] outSyncMode,
  input wire logic [1:0] syncClkSel,
  input wire logic syncClkEnable,
  input wire logic fabricSyncRst,
  // Software control
  input wire logic [7:0] swControl,
  input wire logic [7:0] latchSetMask,
  input wire logic [7:0] latchClearMask,
  input wire logic [7:0] pinOutputLatch,
  input wire logic [7:0] pinStateReadback
);
  logic [36:0] cfg;
  logic [36:0] prevCfg;
  logic [2:0] age;
  logic steady;
  logic hf;
  assign cfg = {inSyncMode, outSyncMode, syncClkSel, syncClkEnable, fabricSyncRst, swControl[0]};
  assign steady = cfg == prevCfg;
  assign hf = steady && age > 3'h4 && syncClkSel == 2'h0 && syncClkEnable && !fabricSyncRst;
  // Latency checks wait until the setup has settled, since stage flops keep old data.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prevCfg <= '0;
      age <= 3'h0;
    end else begin
      prevCfg <= cfg;
      age <= !steady ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_IN_PASS: assert property (hf && inSyncMode[1] == inSyncMode[0]
    |-> fabricIn[0] == $past(pinIn[0], 2)) else $error("straight input");
  AST_IN_TWO: assert property (hf && inSyncMode[1:0] == 2'h2
    |-> fabricIn[0] == $past(pinIn[0], 4)) else $error("double input");
  AST_OUT_PASS: assert property (outSyncMode[1:0] == 2'h0
    |-> pinOut[0] == (swControl[0] ? pinOutputLatch[0] : fabricOut[0])) else $error("out");
  AST_OUT_ONE: assert property (hf && outSyncMode[1:0] == 2'h1 && !swControl[0]
    |-> pinOut[0] == $past(fabricOut[0])) else $error("single output");
  AST_OUT_INV: assert property (steady && outSyncMode[3:0] == 4'he
    |-> pinOut[0] != pinOut[1]) else $error("clock pins");
  AST_LATCH: assert property ((latchSetMask | latchClearMask) != 8'h00
    |=> pinOutputLatch == (($past(pinOutputLatch) & ~$past(latchClearMask))
    | $past(latchSetMask))) else $error("latch");
  AST_READBACK: assert property (!$past(sys_rst, 3)
    |-> pinStateReadback == $past(pinIn, 3)) else $error("readback");
  AST_SYNC_RST: assert property (steady && fabricSyncRst && inSyncMode[1:0] == 2'h1
    |-> !fabricIn[0]) else $error("sync reset");
endmodule : gpsa_port_adapter_sva
bind gpsa_port_adapter gpsa_port_adapter_sva chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .pinIn(pinIn), .pinOut(pinOut), .fabricOut(fabricOut), .fabricIn(fabricIn),
  .inSyncMode(inSyncMode), .outSyncMode(outSyncMode), .syncClkSel(syncClkSel),
  .syncClkEnable(syncClkEnable), .fabricSyncRst(fabricSyncRst), .swControl(swControl),
  .latchSetMask(latchSetMask), .latchClearMask(latchClearMask),
  .pinOutputLatch(pinOutputLatch), .pinStateReadback(pinStateReadback));
`default_nettype wire

// ==== verif/test_gpsa_port_adapter.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_gpsa_port_adapter;
  logic clk_sys, sys_rst, fabricSyncRst, syncClkEnable, run, fabricSyncClk, configError;
  logic [1:0] syncClkSel;
  logic [7:0] pinIn, swControl, latchSetMask, latchClearMask, fabricOut, pinOut, fabricIn;
  logic [7:0] pinOutputLatch, pinStateReadback;
  logic [15:0] inSyncMode, outSyncMode;
  int bad_count, n_compared, n;
  gpsa_fabric_model fab_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
    .fabricOut(fabricOut), .fabricSyncClk(fabricSyncClk));
  gpsa_port_adapter dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(pinIn),
    .pinOut(pinOut), .fabricOut(fabricOut), .fabricIn(fabricIn),
    .fabricSyncClk(fabricSyncClk), .fabricSyncRst(fabricSyncRst), .inSyncMode(inSyncMode),
    .outSyncMode(outSyncMode), .syncClkSel(syncClkSel), .syncClkPin(3'h0),
    .syncClkEnable(syncClkEnable), .syncRstSel(1'b0), .syncRstPin(3'h0),
    .configError(configError), .swControl(swControl), .latchSetMask(latchSetMask),
    .latchClearMask(latchClearMask), .pinOutputLatch(pinOutputLatch),
    .pinStateReadback(pinStateReadback));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic complete_run;
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic t_latch;
    swControl = 8'h0f;
    latchSetMask = 8'h04;
    tick(1);
    latchSetMask = 8'hff;
    latchClearMask = 8'h04;
    cmp(pinOutputLatch, 8'h04);
    cmp(pinOut, 8'h04 | (fabricOut & 8'hf0));
    tick(1);
    latchSetMask = 8'h00;
    cmp(pinOutputLatch, 8'hff);
    tick(1);
    latchClearMask = 8'h00;
    cmp(pinOutputLatch, 8'hfb);
  endtask : t_latch
  task automatic t_in;
    logic [7:0] lat [4] = '{8'h02, 8'h03, 8'h04, 8'h02};
    for (int m = 0; m < 4; m++) begin
      inSyncMode = {8{m[1:0]}};
      pinIn = 8'h00;
      tick(6);
      pinIn = 8'h5a;
      n = 0;
      while (fabricIn !== 8'h5a && n < 9) begin
        tick(1);
        n++;
      end
      cmp(8'(n), lat[m]);
    end
    tick(1);
    cmp(pinStateReadback, 8'h5a);
    cmp({7'h0, configError}, 8'h00);
  endtask : t_in
  task automatic t_gate;
    inSyncMode = 16'h5555;
    syncClkEnable = 1'b0;
    pinIn = 8'hff;
    tick(6);
    cmp(fabricIn, 8'h5a);
    syncClkEnable = 1'b1;
    tick(4);
    cmp(fabricIn, 8'hff);
    fabricSyncRst = 1'b1;
    tick(2);
    cmp(fabricIn, 8'h00);
    fabricSyncRst = 1'b0;
    syncClkSel = 2'h1;
    run = 1'b1;
    pinIn = 8'h3c;
    tick(12);
    cmp(fabricIn, 8'h3c);
    run = 1'b0;
    pinIn = 8'hff;
    tick(8);
    cmp(fabricIn, 8'h3c);
  endtask : t_gate
  task automatic t_out;
    swControl = 8'h00;
    syncClkSel = 2'h0;
    outSyncMode = 16'h5555;
    tick(8);
    cmp(pinOut, fabricOut - 8'h35);
    syncClkSel = 2'h1;
    outSyncMode = 16'heeee;
    run = 1'b1;
    tick(8);
    cmp((pinOut ^ (pinOut >> 1)) & 8'h55, 8'h55);
    syncClkSel = 2'h0;
    tick(8);
    cmp((pinOut ^ (pinOut >> 1)) & 8'h55, 8'h55);
  endtask : t_out
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {pinIn, swControl, latchSetMask, latchClearMask, inSyncMode, outSyncMode} = 64'h0;
    {syncClkSel, fabricSyncRst, run} = 4'h0;
    syncClkEnable = 1'b1;
    sys_rst = 1'b1;
    tick(16);
    sys_rst = 1'b0;
    tick(1);
    t_latch;
    t_in;
    t_gate;
    t_out;
    complete_run;
  end
  // About eighteen times the length of the sequence above.
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    complete_run;
  end
endmodule : test_gpsa_port_adapter
`default_nettype wire
